// ===== irp_host_model.sv
`timescale 1ns/1ps
module irp_host_model (
    input  wire logic i_pin_b,
    input  wire logic i_pin_b_oe,
    input  wire logic i_drive,
    input  wire logic i_level,
    output logic      o_pin_b_wire
);
    // The host only drives pin B once the device has let go, else a pull-up holds it high.
    assign o_pin_b_wire = i_pin_b_oe ? i_pin_b : (i_drive ? i_level : 1'b1);
endmodule // irp_host_model

// ===== irp_pin_mux.sv
`timescale 1ns/1ps
module irp_pin_mux (
    irp_route_if.mux bus
);
    import irp_pkg::*;

    // Each enabled source is steered to one pin, or to none when the strap drops it.
    always_comb begin
        logic sel_b;
        logic drop;
        sel_b     = 1'b0;
        drop      = 1'b0;
        bus.hit_a = 1'b0;
        bus.hit_b = 1'b0;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            sel_b = bus.route[i];
            drop  = 1'b0;
            if (bus.strap_mode) begin
                if (i == BIT_STARTUP) begin
                    sel_b = 1'b1;
                end else begin
                    // Trigger mode reads every select bit as 0, so nothing is unrouted then.
                    drop  = bus.route[i] & ~bus.trigger_fn;
                end
            end
            // The pin is an input in trigger mode, so a second-pin choice falls back.
            if (bus.trigger_fn) begin
                sel_b = 1'b0;
            end
            bus.hit_a = bus.hit_a | (bus.src_active[i] & ~drop & ~sel_b);
            bus.hit_b = bus.hit_b | (bus.src_active[i] & ~drop & sel_b);
        end
    end

endmodule // irp_pin_mux

// ===== irp_pkg.sv
package irp_pkg;

    // Register addresses on the plain register port.
    localparam logic [7:0] ADDR_INT_ENABLE  = 8'h20;
    localparam logic [7:0] ADDR_PIN_SELECT  = 8'h21;
    localparam logic [7:0] ADDR_SENS_CONFIG = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h31;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h32;
    localparam logic [7:0] ADDR_PIN_STATE   = 8'h33;

    // Source bit positions, shared by enable, select, status and mask registers.
    localparam int BIT_DATA_READY  = 7;
    localparam int BIT_BUFFER      = 6;
    localparam int BIT_CHANGE_OUT  = 5;
    localparam int BIT_CHANGE_IN   = 4;
    localparam int BIT_ORIENTATION = 3;
    localparam int BIT_AUTOSLEEP   = 2;
    localparam int BIT_STARTUP     = 1;
    localparam int BIT_WAKE_STATE  = 0;
    localparam int NUM_SOURCES     = 8;

    // Configuration register field positions.
    localparam int CFG_POLARITY    = 0;
    localparam int CFG_TRIGGER_FN  = 1;

    // Pin state register field positions.
    localparam int ST_PIN_A        = 0;
    localparam int ST_PIN_B        = 1;
    localparam int ST_EXT_TRIGGER  = 2;
    localparam int ST_STRAP_MODE   = 3;
    localparam int ST_PIN_B_OE     = 4;

    // Values after reset.
    localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
    localparam logic [7:0] RST_PIN_SELECT  = 8'h00;
    localparam logic [1:0] RST_SENS_CONFIG = 2'h0;
    localparam logic [7:0] RST_IRQ_STATUS  = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK    = 8'h00;

    // System mode code that means the device is awake.
    localparam logic [1:0] SYS_MODE_WAKE   = 2'h1;

    // Cycles after reset release before the synchronised strap is caught.
    localparam logic [1:0] STRAP_SETTLE    = 2'h3;

endpackage

// ===== irp_route_if.sv
`timescale 1ns/1ps
interface irp_route_if;
    logic [7:0] src_active;
    logic [7:0] route;
    logic       trigger_fn;
    logic       strap_mode;
    logic       hit_a;
    logic       hit_b;

    modport ctrl (
        output src_active,
        output route,
        output trigger_fn,
        output strap_mode,
        input  hit_a,
        input  hit_b
    );

    modport mux (
        input  src_active,
        input  route,
        input  trigger_fn,
        input  strap_mode,
        output hit_a,
        output hit_b
    );
endinterface

// ===== irp_router.sv
// Summary of operation
// - Data-ready goes to pin A when select bit 7 is 0, else pin B.
// - Buffer event is OR of overflow, watermark, gate error; bit 6 picks pin.
// - Outside-thresholds change event routed by select bit 5.
// - Within-thresholds change event routed by select bit 4.
// - Orientation event routed by select bit 3.
// - Auto wake/sleep event routed by select bit 2.
// - Startup-complete event routed by select bit 1.
// - Startup routing bit survives soft reset; others return to reset value.
// - Wake power-state output routed by select bit 0.
// - In trigger-input mode, select bits set to 1 are ignored.
// - Strap mode: sources other than startup selecting pin B reach no pin, except in trigger-input mode, where they go to pin A.
// - Strap mode: startup event goes to pin B, except in trigger-input mode, where it goes to pin A.
// - Routing select is an 8-bit read/write register at 0x21, reset zero.
// - A source reaches a pin only while its enable bit is set; startup's bit 1 is a disable, overridden by strap.
// - Enabled wake output holds active level in wake mode, opposite otherwise.
`timescale 1ns/1ps
module irp_router (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_soft_reset,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_data_ready,
    input  wire logic       i_buffer_overflow_flag,
    input  wire logic       i_buffer_watermark_flag,
    input  wire logic       i_buffer_gate_error,
    input  wire logic       i_change_outside,
    input  wire logic       i_change_within,
    input  wire logic       i_orientation,
    input  wire logic       i_autosleep,
    input  wire logic       i_startup_done_event,
    input  wire logic [1:0] i_sys_mode,
    input  wire logic       i_startup_strap_mode,
    input  wire logic       i_irq_pin_b,
    output logic            o_irq_pin_a,
    output logic            o_irq_pin_b,
    output logic            o_irq_pin_b_oe,
    output logic            o_ext_trigger,
    output logic            o_irq
);
    import irp_pkg::*;

    // Every flip-flop of the block apart from the reset synchroniser.
    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] select;
        logic [1:0] config_bits;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic       strap_s1;
        logic       strap_s2;
        logic       strap_mode;
        logic [1:0] strap_wait;
        logic       trig_s1;
        logic       trig_s2;
        logic       pin_a;
        logic       pin_b;
        logic       pin_b_oe;
        logic       irq;
    } irp_state_t;

    irp_state_t  state;
    irp_state_t  next_state;
    logic        rst_s1;
    logic        rst_s2;
    logic [7:0]  src_raw;
    logic [7:0]  src_active;
    logic        polarity;
    logic        trigger_fn;
    logic        hit_a;
    logic        hit_b;
    logic        wake_now;
    logic        sel_hit;

    irp_route_if route_bus ();

    // Reset is released through two flops so that no flop sees a ragged release.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // The wake source is a level derived from the system mode.
    assign wake_now   = (i_sys_mode == SYS_MODE_WAKE);
    assign polarity   = state.config_bits[CFG_POLARITY];
    assign trigger_fn = state.config_bits[CFG_TRIGGER_FN];

    // Raw source levels laid out in the select register order.
    always_comb begin
        src_raw                  = 8'h00;
        src_raw[BIT_DATA_READY]  = i_data_ready;
        src_raw[BIT_BUFFER]      = i_buffer_overflow_flag
                                 | i_buffer_watermark_flag
                                 | i_buffer_gate_error;
        src_raw[BIT_CHANGE_OUT]  = i_change_outside;
        src_raw[BIT_CHANGE_IN]   = i_change_within;
        src_raw[BIT_ORIENTATION] = i_orientation;
        src_raw[BIT_AUTOSLEEP]   = i_autosleep;
        src_raw[BIT_STARTUP]     = i_startup_done_event;
        src_raw[BIT_WAKE_STATE]  = wake_now;
    end

    // Enables gate each source; the startup bit of the enable register is a disable.
    always_comb begin
        src_active              = src_raw & state.enable;
        src_active[BIT_STARTUP] = src_raw[BIT_STARTUP] & ~state.enable[BIT_STARTUP];
    end

    // The strap forces the startup event on, whatever the disable bit holds.
    assign route_bus.src_active = state.strap_mode
                                ? (src_active | (src_raw & 8'h02))
                                : src_active;
    assign route_bus.route      = state.select;
    assign route_bus.trigger_fn = trigger_fn;
    assign route_bus.strap_mode = state.strap_mode;
    assign hit_a                = route_bus.hit_a;
    assign hit_b                = route_bus.hit_b;

    irp_pin_mux u_pin_mux (
        .bus (route_bus)
    );

    // A select access is only noted here so that the read path stays readable.
    assign sel_hit = (i_addr == ADDR_PIN_SELECT);

    // Next-state logic: register port, sticky status, strap capture and pin drive.
    always_comb begin
        next_state          = state;
        next_state.rdata    = 8'h00;

        // The two synchronisers; their first stages feed nothing but the second.
        next_state.strap_s1 = i_startup_strap_mode;
        next_state.strap_s2 = state.strap_s1;
        next_state.trig_s1  = i_irq_pin_b;
        next_state.trig_s2  = state.trig_s1;

        // The strap is caught once, after the synchroniser has had time to fill.
        if (state.strap_wait != STRAP_SETTLE) begin
            next_state.strap_wait = state.strap_wait + 2'h1;
            next_state.strap_mode = state.strap_s2;
        end

        // Register writes.
        if (i_wr) begin
            case (i_addr)
                ADDR_INT_ENABLE: begin
                    next_state.enable = i_wdata;
                end
                ADDR_PIN_SELECT: begin
                    next_state.select = i_wdata;
                end
                ADDR_SENS_CONFIG: begin
                    next_state.config_bits = i_wdata[1:0];
                end
                ADDR_IRQ_MASK: begin
                    next_state.mask = i_wdata;
                end
                default: begin
                    next_state.enable = state.enable;
                end
            endcase
        end

        // Register reads; the data stand only in the following cycle.
        if (i_rd) begin
            case (i_addr)
                ADDR_INT_ENABLE: begin
                    next_state.rdata = state.enable;
                end
                ADDR_PIN_SELECT: begin
                    next_state.rdata = sel_hit ? state.select : 8'h00;
                end
                ADDR_SENS_CONFIG: begin
                    next_state.rdata = {6'h00, state.config_bits};
                end
                ADDR_IRQ_STATUS: begin
                    next_state.rdata  = state.status;
                    next_state.status = RST_IRQ_STATUS;
                end
                ADDR_IRQ_MASK: begin
                    next_state.rdata = state.mask;
                end
                ADDR_PIN_STATE: begin
                    next_state.rdata[ST_PIN_A]       = state.pin_a;
                    next_state.rdata[ST_PIN_B]       = state.pin_b;
                    next_state.rdata[ST_EXT_TRIGGER] = state.trig_s2;
                    next_state.rdata[ST_STRAP_MODE]  = state.strap_mode;
                    next_state.rdata[ST_PIN_B_OE]    = state.pin_b_oe;
                end
                default: begin
                    next_state.rdata = 8'h00;
                end
            endcase
        end

        // A source that is live in the cycle of a clearing read still sets its bit.
        next_state.status = next_state.status | route_bus.src_active;

        // Soft reset restores defaults but keeps the startup routing and disable bits.
        if (i_soft_reset) begin
            next_state.select              = RST_PIN_SELECT;
            next_state.select[BIT_STARTUP] = state.select[BIT_STARTUP];
            next_state.enable              = RST_INT_ENABLE;
            next_state.enable[BIT_STARTUP] = state.enable[BIT_STARTUP];
            next_state.config_bits         = RST_SENS_CONFIG;
            next_state.status              = RST_IRQ_STATUS;
            next_state.mask                = RST_IRQ_MASK;
        end

        // Pins show the active level while any routed source is live.
        next_state.pin_a    = hit_a ? polarity : ~polarity;
        next_state.pin_b    = hit_b ? polarity : ~polarity;
        next_state.pin_b_oe = ~trigger_fn;

        // One level interrupt for software, from the masked sticky bits.
        next_state.irq = |(state.status & state.mask);
    end

    // Power-on reset clears everything but the pins and pin B enable, which start at 1, including the bits a soft reset keeps.
    always_ff @(posedge i_clk or negedge rst_s2) begin
        if (!rst_s2) begin
            state             <= '0;
            state.enable      <= RST_INT_ENABLE;
            state.select      <= RST_PIN_SELECT;
            state.config_bits <= RST_SENS_CONFIG;
            state.status      <= RST_IRQ_STATUS;
            state.mask        <= RST_IRQ_MASK;
            state.pin_a       <= 1'b1;
            state.pin_b       <= 1'b1;
            state.pin_b_oe    <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops.
    assign o_rdata        = state.rdata;
    assign o_irq_pin_a    = state.pin_a;
    assign o_irq_pin_b    = state.pin_b;
    assign o_irq_pin_b_oe = state.pin_b_oe;
    assign o_ext_trigger  = state.trig_s2;
    assign o_irq          = state.irq;

endmodule // irp_router

// ===== irp_router_asserts.sv
`timescale 1ns/1ps
module irp_router_asserts (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic       i_soft_reset,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_data_ready,
    input wire logic       i_buffer_watermark_flag,
    input wire logic       i_startup_done_event,
    input wire logic [1:0] i_sys_mode,
    input wire logic       i_startup_strap_mode,
    input wire logic       o_irq_pin_a,
    input wire logic       o_irq_pin_b,
    input wire logic       o_irq_pin_b_oe
);
    import irp_pkg::*;
    logic [7:0] en;
    logic [7:0] sel;
    logic [1:0] cfg;
    // Shadow copy of enable, select and config; soft reset keeps only bit 1 of the first two.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            en  <= 8'h00;
            sel <= 8'h00;
            cfg <= 2'h0;
        end else if (i_soft_reset) begin
            en  <= en & 8'h02;
            sel <= sel & 8'h02;
            cfg <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == ADDR_INT_ENABLE) en <= i_wdata;
            if (i_addr == ADDR_PIN_SELECT) sel <= i_wdata;
            if (i_addr == ADDR_SENS_CONFIG) cfg <= i_wdata[1:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Pins lag their cause by one cycle, so each antecedent looks one edge back.
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
    property p_sel_read;
        $past(i_rd && i_addr == ADDR_PIN_SELECT) |-> o_rdata == $past(sel);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select readback wrong");
    property p_drdy_a;
        $past(en[7] && i_data_ready && (!sel[7] || cfg[1])) |-> o_irq_pin_a == $past(cfg[0]);
    endproperty
    a_drdy_a: assert property (p_drdy_a) else $error("data ready missing on pin A");
    property p_buf_a;
        $past(en[6] && i_buffer_watermark_flag && !sel[6]) |-> o_irq_pin_a == $past(cfg[0]);
    endproperty
    a_buf_a: assert property (p_buf_a) else $error("buffer event missing on pin A");
    property p_boot_b;
        $past(!en[1] && i_startup_done_event && sel[1] && !cfg[1]) |-> o_irq_pin_b == $past(cfg[0]);
    endproperty
    a_boot_b: assert property (p_boot_b) else $error("startup missing on pin B");
    property p_oe;
        o_irq_pin_b_oe == !$past(cfg[1]);
    endproperty
    a_oe: assert property (p_oe) else $error("pin B enable wrong");
    property p_wake;
        $past(en[0] && !sel[0] && i_sys_mode == SYS_MODE_WAKE) |-> o_irq_pin_a == $past(cfg[0]);
    endproperty
    a_wake: assert property (p_wake) else $error("wake level missing on pin A");
    property p_strap_boot;
        $past(i_startup_strap_mode && i_startup_done_event && !cfg[1]) |-> o_irq_pin_b == $past(cfg[0]);
    endproperty
    a_strap_boot: assert property (p_strap_boot) else $error("strap startup not on pin B");
    c_soft: cover property (i_soft_reset);
    c_trig: cover property (!o_irq_pin_b_oe);
    c_strap: cover property (i_startup_strap_mode && i_startup_done_event);
endmodule // irp_router_asserts
bind irp_router irp_router_asserts u_irp_router_asserts (.i_clk, .i_rstn, .i_soft_reset,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_data_ready, .i_buffer_watermark_flag,
    .i_startup_done_event, .i_sys_mode, .i_startup_strap_mode, .o_irq_pin_a, .o_irq_pin_b,
    .o_irq_pin_b_oe);

// ===== irp_tb.sv
`timescale 1ns/1ps
module testbench;
    import irp_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rstn = 1'b0;
    logic       i_soft_reset = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [7:0] src = 8'h00;
    logic [1:0] bufx = 2'h0;
    logic       strap = 1'b0;
    logic       host_drive = 1'b0;
    logic       host_level = 1'b1;
    logic [7:0] o_rdata;
    logic       o_irq_pin_a;
    logic       o_irq_pin_b;
    logic       o_irq_pin_b_oe;
    logic       o_ext_trigger;
    logic       o_irq;
    logic       pin_b_wire;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    // Each bit of src is one event source, in select-bit order; bit 0 switches wake mode.
    irp_router u_irp_router (.i_clk, .i_rstn, .i_soft_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_data_ready(src[7]), .i_buffer_overflow_flag(src[6]),
        .i_buffer_watermark_flag(bufx[0]), .i_buffer_gate_error(bufx[1]),
        .i_change_outside(src[5]), .i_change_within(src[4]), .i_orientation(src[3]),
        .i_autosleep(src[2]), .i_startup_done_event(src[1]),
        .i_sys_mode(src[0] ? 2'h1 : 2'h2), .i_startup_strap_mode(strap),
        .i_irq_pin_b(pin_b_wire), .o_irq_pin_a, .o_irq_pin_b, .o_irq_pin_b_oe, .o_ext_trigger,
        .o_irq);
    irp_host_model u_irp_host_model (.i_pin_b(o_irq_pin_b), .i_pin_b_oe(o_irq_pin_b_oe),
        .i_drive(host_drive), .i_level(host_level), .o_pin_b_wire(pin_b_wire));
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic put(input logic [7:0] v);
        @(posedge i_clk);
        src <= v;
    endtask
    // Pins answer one cycle after a source change, so two edges leave a settled level.
    task automatic pins(input logic [7:0] e);
        repeat (2) @(posedge i_clk);
        #1 chk({6'h00, o_irq_pin_b, o_irq_pin_a}, e);
    endtask
    task automatic reset_dut();
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (5) @(posedge i_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_regs();
        rd(ADDR_PIN_SELECT, 8'h00);
        wr(ADDR_PIN_SELECT, 8'hA5);
        rd(ADDR_PIN_SELECT, 8'hA5);
        rd(8'h7F, 8'h00);
        $display("test regs done");
    endtask
    // Every source alone, first on pin A then on pin B, with active-low pins.
    task automatic t_route();
        wr(ADDR_INT_ENABLE, 8'hFD);
        for (int b = 0; b < 8; b++) begin
            for (int s = 0; s < 2; s++) begin
                wr(ADDR_PIN_SELECT, s ? (8'h01 << b) : 8'h00);
                put(8'h01 << b);
                pins(s ? 8'h01 : 8'h02);
                put(8'h00);
            end
        end
        $display("test route done");
    endtask
    task automatic t_pol();
        wr(ADDR_SENS_CONFIG, 8'h01);
        wr(ADDR_INT_ENABLE, 8'h02);
        put(8'hFF);
        pins(8'h00);
        wr(ADDR_INT_ENABLE, 8'h43);
        pins(8'h01);
        put(8'h00);
        pins(8'h00);
        for (int i = 1; i < 3; i++) begin
            @(posedge i_clk);
            bufx <= i[1:0];
            pins(8'h01);
        end
        @(posedge i_clk);
        bufx <= 2'h0;
        $display("test pol done");
    endtask
    // Trigger function sends data ready, selected for pin B, to pin A and hands pin B to the host.
    task automatic t_trig();
        wr(ADDR_SENS_CONFIG, 8'h02);
        wr(ADDR_PIN_SELECT, 8'hFF);
        wr(ADDR_INT_ENABLE, 8'h80);
        put(8'h80);
        // Pin B is released but its own output stays at the inactive level.
        pins(8'h02);
        chk({7'h00, o_irq_pin_b_oe}, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            host_drive <= 1'b1;
            host_level <= i[0];
            repeat (5) @(posedge i_clk);
            #1 chk({7'h00, o_ext_trigger}, {7'h00, i[0]});
        end
        put(8'h00);
        host_drive <= 1'b0;
        $display("test trig done");
    endtask
    task automatic t_soft();
        wr(ADDR_INT_ENABLE, 8'h82);
        @(posedge i_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_clk);
        i_soft_reset <= 1'b0;
        rd(ADDR_PIN_SELECT, 8'h02);
        rd(ADDR_INT_ENABLE, 8'h02);
        rd(ADDR_SENS_CONFIG, 8'h00);
        $display("test soft done");
    endtask
    task automatic t_irq();
        wr(ADDR_INT_ENABLE, 8'h82);
        wr(ADDR_PIN_SELECT, 8'h00);
        put(8'h80);
        put(8'h00);
        repeat (3) @(posedge i_clk);
        #1 chk({7'h00, o_irq}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h80);
        repeat (2) @(posedge i_clk);
        #1 chk({7'h00, o_irq}, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h80);
        repeat (2) @(posedge i_clk);
        #1 chk({7'h00, o_irq}, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_strap();
        @(posedge i_clk);
        strap <= 1'b1;
        reset_dut();
        wr(ADDR_INT_ENABLE, 8'h82);
        wr(ADDR_PIN_SELECT, 8'h80);
        put(8'h80);
        pins(8'h03);
        put(8'h02);
        pins(8'h01);
        put(8'h00);
        $display("test strap done");
    endtask
    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        reset_dut();
        t_regs();
        t_route();
        t_pol();
        t_trig();
        t_soft();
        t_irq();
        t_strap();
        test_done();
    end
endmodule // testbench
